// [dac_bank_defines.svh]
// constants for the serial-loaded converter channel bank
`ifndef DAC_BANK_DEFINES_SVH
`define DAC_BANK_DEFINES_SVH

`define WORD_BITS      12
`define WORD_MSB       11
`define ADDR_MSB       11
`define ADDR_LSB       8
`define DATA_MSB       7
`define DATA_LSB       0
`define CODE_BITS      8
`define ADDR_BITS      4
`define NUM_CHANNELS   12
`define LAST_ADDR      4'hB
`define MIDSCALE_CODE  8'h80
`define WORD_RESET     12'h000
`define ADDR_RESET     4'h0
`define LOAD_IDLE      2'b00
`define LOAD_FRAME     2'b01
`define LOAD_COMMIT    2'b11
`define LOAD_SETTLE    2'b10

`endif

// [dac_bank_pkg.sv]
// types shared by the converter channel bank
package dac_bank_pkg;
  `include "dac_bank_defines.svh"

  typedef logic [`CODE_BITS-1:0]                     chan_code_t;
  typedef logic [`ADDR_BITS-1:0]                     chan_addr_t;
  typedef logic [`WORD_MSB:0]                        serial_word_t;
  typedef logic [`NUM_CHANNELS-1:0][`CODE_BITS-1:0]  chan_bank_t;

  typedef enum logic [1:0]
  {
    LOAD_IDLE_S   = `LOAD_IDLE,
    LOAD_FRAME_S  = `LOAD_FRAME,
    LOAD_COMMIT_S = `LOAD_COMMIT,
    LOAD_SETTLE_S = `LOAD_SETTLE
  } load_state_t;
endpackage : dac_bank_pkg

// [serial_shift_link.sv]
// serial-to-parallel shift register clocked by the link clock
`timescale 1ns/10ps
`include "dac_bank_defines.svh"
module serial_shift_link
  import dac_bank_pkg::*;
(
  input  wire logic                  SCLK_I,
  input  wire logic                  CS_N_I,
  input  wire logic                  SERIAL_IN_I,
  output      dac_bank_pkg::serial_word_t WORD_O
);
  import dac_bank_pkg::*;

  serial_word_t shift_ff;

  // rising edge only; chip select high freezes the word
  always_ff @(posedge SCLK_I)
  begin
    if (!CS_N_I)
    begin
      shift_ff <= {shift_ff[`WORD_MSB-1:0], SERIAL_IN_I};
    end
  end

  assign WORD_O = shift_ff;
endmodule : serial_shift_link

// [dac_channel_bank.sv]
// twelve-channel converter code bank loaded over a three-wire serial link
// Summary of operation
// - twelve independent 8-bit channel registers hold their codes until rewritten.
// - channel registers load only from the internal serial shift register, apart from code 80 hex on reset and preset.
// - the first four bits of a word are the channel address and the last eight the code.
// - serial data is sampled on the rising serial clock edge only.
// - the host holds chip select low while shifting and its rise loads the addressed channel.
// - address 0000 selects the first output up to address 1011 for the twelfth.
// - the preset loads every channel with code 80 hex without waiting for a clock.
// - the preset exists only on the fixed low reference variant.
// - power-down keeps all codes so outputs resume their old settings afterwards.
// - with chip select low each rising clock shifts one bit in, with it high clocks do nothing.
// - only the last twelve bits shifted are used, with bits left from earlier frames filling a short frame.
`timescale 1ns/10ps
`include "dac_bank_defines.svh"
module dac_channel_bank
  import dac_bank_pkg::*;
#(
  parameter bit HAS_PRESET = 1'b1
)
(
  input  wire logic                  CLK_I,
  input  wire logic                  RST_N_I,
  input  wire logic                  SCLK_I,
  input  wire logic                  CS_N_I,
  input  wire logic                  SERIAL_IN_I,
  input  wire logic                  MIDSCALE_PRESET_N_I,
  input  wire logic                  POWER_DOWN_N_I,
  output      dac_bank_pkg::chan_bank_t CHANNEL_CODES_O,
  output      logic                  CHANNEL_ENABLE_O,
  output      logic                  LOAD_DONE_O,
  output      logic                  ADDR_REJECT_O
);
  import dac_bank_pkg::*;

  serial_word_t link_word;
  serial_word_t word_meta_ff;
  serial_word_t word_sync_ff;
  serial_word_t held_word_ff;
  logic         cs_meta_ff;
  logic         cs_sync_ff;
  logic         cs_prev_ff;
  logic         pd_meta_ff;
  logic         pd_sync_ff;
  logic         preset_n;
  logic         cs_rise;
  logic         cs_fall;
  load_state_t  state_ff;
  load_state_t  nxt_state;
  chan_bank_t   chan_ff;
  logic         load_done_ff;
  logic         reject_ff;
  logic         enable_ff;
  chan_addr_t   commit_addr;
  chan_code_t   commit_code;
  logic         commit_hit;

  logic         preset_meta_ff;
  logic         preset_sync_ff;

  // field decoders of a serial word
  function automatic chan_addr_t word_addr(input serial_word_t w);
    word_addr = w[`ADDR_MSB:`ADDR_LSB];
  endfunction : word_addr

  function automatic chan_code_t word_code(input serial_word_t w);
    word_code = w[`DATA_MSB:`DATA_LSB];
  endfunction : word_code

  function automatic logic addr_valid(input chan_addr_t a);
    addr_valid = (a <= `LAST_ADDR);
  endfunction : addr_valid

  function automatic logic in_commit(input load_state_t s);
    in_commit = (s == LOAD_COMMIT_S);
  endfunction : in_commit

  // link-domain shift register
  serial_shift_link u_shift
  (
    .SCLK_I      (SCLK_I),
    .CS_N_I      (CS_N_I),
    .SERIAL_IN_I (SERIAL_IN_I),
    .WORD_O      (link_word)
  );

  // chip select crossing into the system clock
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      cs_meta_ff <= 1'b1;
      cs_sync_ff <= 1'b1;
    end
    else
    begin
      cs_meta_ff <= CS_N_I;
      cs_sync_ff <= cs_meta_ff;
    end
  end

  // history for edge detection, idle level after reset
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      cs_prev_ff <= 1'b1;
    end
    else
    begin
      cs_prev_ff <= cs_sync_ff;
    end
  end

  // word is quiet while chip select is high, so two stages suffice
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      word_meta_ff <= `WORD_RESET;
      word_sync_ff <= `WORD_RESET;
    end
    else
    begin
      word_meta_ff <= link_word;
      word_sync_ff <= word_meta_ff;
    end
  end

  // word copied once on the chip select rise, immune to the next frame
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      held_word_ff <= `WORD_RESET;
    end
    else if (cs_rise && (state_ff == LOAD_FRAME_S))
    begin
      held_word_ff <= word_sync_ff;
    end
  end

  // power-down crossing
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      pd_meta_ff <= 1'b1;
      pd_sync_ff <= 1'b1;
    end
    else
    begin
      pd_meta_ff <= POWER_DOWN_N_I;
      pd_sync_ff <= pd_meta_ff;
    end
  end

  assign cs_rise = cs_sync_ff & ~cs_prev_ff;
  assign cs_fall = ~cs_sync_ff & cs_prev_ff;

  // load sequencer
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      LOAD_IDLE_S:
      begin
        if (cs_fall)
        begin
          nxt_state = LOAD_FRAME_S;
        end
      end
      LOAD_FRAME_S:
      begin
        if (cs_rise)
        begin
          nxt_state = LOAD_COMMIT_S;
        end
      end
      LOAD_COMMIT_S:
      begin
        nxt_state = LOAD_SETTLE_S;
      end
      LOAD_SETTLE_S:
      begin
        if (cs_fall)
        begin
          nxt_state = LOAD_FRAME_S;
        end
        else
        begin
          nxt_state = LOAD_IDLE_S;
        end
      end
    endcase
  end

  // sequencer state register
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      state_ff <= LOAD_IDLE_S;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // fields of the held word
  assign commit_addr = word_addr(held_word_ff);
  assign commit_code = word_code(held_word_ff);
  assign commit_hit  = in_commit(state_ff) && addr_valid(commit_addr);

  // variant without preset ties the preset off
  assign preset_n = MIDSCALE_PRESET_N_I | ~HAS_PRESET;

  // preset release retimed so writes resume on a clean edge
  always_ff @(posedge CLK_I or negedge preset_n)
  begin
    if (!preset_n)
    begin
      preset_meta_ff <= 1'b0;
      preset_sync_ff <= 1'b0;
    end
    else
    begin
      preset_meta_ff <= 1'b1;
      preset_sync_ff <= preset_meta_ff;
    end
  end

  // channel registers; preset acts with no clock
  always_ff @(posedge CLK_I or negedge preset_n)
  begin
    if (!preset_n)
    begin
      for (int i = 0; i < `NUM_CHANNELS; i++)
      begin
        chan_ff[i] <= `MIDSCALE_CODE;
      end
    end
    else if (!RST_N_I || !preset_sync_ff)
    begin
      for (int i = 0; i < `NUM_CHANNELS; i++)
      begin
        chan_ff[i] <= `MIDSCALE_CODE;
      end
    end
    else if (commit_hit)
    begin
      chan_ff[commit_addr] <= commit_code;
    end
  end

  // load pulse, one cycle wide
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      load_done_ff <= 1'b0;
    end
    else
    begin
      load_done_ff <= commit_hit;
    end
  end

  // reject pulse for addresses beyond the last channel
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      reject_ff <= 1'b0;
    end
    else
    begin
      reject_ff <= in_commit(state_ff) && !addr_valid(commit_addr);
    end
  end

  // power-down gates outputs only, never the codes
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      enable_ff <= 1'b1;
    end
    else
    begin
      enable_ff <= pd_sync_ff;
    end
  end

  // outputs straight from the flops
  assign CHANNEL_CODES_O  = chan_ff;
  assign CHANNEL_ENABLE_O = enable_ff;
  assign LOAD_DONE_O      = load_done_ff;
  assign ADDR_REJECT_O    = reject_ff;
endmodule : dac_channel_bank

// [dac_bank_chk_sva.sv]
// checker for the converter channel bank
`timescale 1ns/10ps
module dac_bank_chk
  import dac_bank_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CS_N_I,
  input wire logic MIDSCALE_PRESET_N_I,
  input wire logic POWER_DOWN_N_I,
  input wire dac_bank_pkg::chan_bank_t CHANNEL_CODES_O,
  input wire logic CHANNEL_ENABLE_O,
  input wire logic LOAD_DONE_O,
  input wire logic ADDR_REJECT_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  AST_PRESET: assert property (!MIDSCALE_PRESET_N_I |-> CHANNEL_CODES_O == {12{8'h80}})
    else $error("codes off midscale");
  AST_PD_OFF: assert property ($fell(POWER_DOWN_N_I) |-> ##[2:4] !CHANNEL_ENABLE_O)
    else $error("enable stuck");
  AST_PD_ON: assert property ($rose(POWER_DOWN_N_I) |-> ##[2:4] CHANNEL_ENABLE_O)
    else $error("enable not back");
  AST_DONE_ONE: assert property (LOAD_DONE_O |=> !LOAD_DONE_O)
    else $error("done too long");
  AST_REJ_ONE: assert property (ADDR_REJECT_O |=> !ADDR_REJECT_O)
    else $error("reject too long");
  AST_REJ_KEEP: assert property (ADDR_REJECT_O |-> CHANNEL_CODES_O == $past(CHANNEL_CODES_O, 3))
    else $error("reject wrote");
  AST_COMMIT: assert property ($rose(CS_N_I) && MIDSCALE_PRESET_N_I |-> ##[4:7] (LOAD_DONE_O || ADDR_REJECT_O))
    else $error("no commit");
  AST_ONLY_LOAD: assert property (!$stable(CHANNEL_CODES_O) && MIDSCALE_PRESET_N_I |-> LOAD_DONE_O)
    else $error("stray change");
  cover property (LOAD_DONE_O);
  cover property (ADDR_REJECT_O);
  cover property (!CHANNEL_ENABLE_O);
endmodule : dac_bank_chk
bind dac_channel_bank dac_bank_chk dac_bank_chk_inst (.*);

// [dac_host_model.sv]
// host model driving the three-wire link
`timescale 1ns/10ps
module dac_host_model
(
  output logic SCLK_O,
  output logic CS_N_O,
  output logic SDO_O
);
  initial SCLK_O = 1'b1;
  initial CS_N_O = 1'b1;
  initial SDO_O = 1'b0;
  // cs_n 1 clocks junk with chip select idle
  task send(input logic [15:0] w, input int n, input logic cs_n);
    CS_N_O = cs_n;
    #10;
    for (int i = n - 1; i >= 0; i--)
    begin
      SCLK_O = 1'b0;
      SDO_O = w[i];
      #6 SCLK_O = 1'b1;
      #6;
    end
    #20 CS_N_O = 1'b1;
    SDO_O = ~SDO_O;
    #60;
  endtask : send
endmodule : dac_host_model

// [dac_channel_bank_test.sv]
// self-checking bench for the converter channel bank
`timescale 1ns/10ps
module dac_channel_bank_test;
  import dac_bank_pkg::*;
  logic clk, rst_n, pre_n, pd_n, en, done, rej;
  wire sclk, cs_n, serial_in;
  chan_bank_t codes;
  logic [7:0] exp_q [12];
  logic [31:0] lfsr = 32'h01BA;
  int miscompares = 0, num_checks = 0, dones = 0, rejs = 0;
  dac_host_model dac_host_model_inst (.SCLK_O(sclk), .CS_N_O(cs_n), .SDO_O(serial_in));
  dac_channel_bank dac_channel_bank_inst (.CLK_I(clk), .RST_N_I(rst_n), .SCLK_I(sclk), .CS_N_I(cs_n),
    .SERIAL_IN_I(serial_in), .MIDSCALE_PRESET_N_I(pre_n), .POWER_DOWN_N_I(pd_n), .CHANNEL_CODES_O(codes),
    .CHANNEL_ENABLE_O(en), .LOAD_DONE_O(done), .ADDR_REJECT_O(rej));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    dones += (done === 1'b1);
    rejs += (rej === 1'b1);
  end
  function logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : next_rand
  task chk_codes();
    num_checks++;
    for (int i = 0; i < 12; i++)
      if (codes[i] !== exp_q[i])
      begin
        miscompares++;
        $display("unexpected %0t channel %0d code %h", $time, i, codes[i]);
      end
  endtask : chk_codes
  task chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected %0t flag %b", $time, got);
    end
  endtask : chk_bit
  task settle();
    repeat (12) @(posedge clk);
    #1;
  endtask : settle
  task write(input logic [15:0] w, input int n);
    int d, r;
    d = dones;
    r = rejs;
    dac_host_model_inst.send(w, n, 1'b0);
    settle();
    if (w[11:8] < 4'hC)
      exp_q[w[11:8]] = w[7:0];
    chk_codes();
    chk_bit(dones - d == 1, w[11:8] < 4'hC);
    chk_bit(rejs - r == 1, w[11:8] >= 4'hC);
  endtask : write
  task complete_run();
    if (miscompares == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run
  initial
  begin
    #100000;
    miscompares++;
    complete_run();
  end
  initial
  begin
    rst_n = 1'b0;
    pre_n = 1'b1;
    pd_n = 1'b1;
    foreach (exp_q[i]) exp_q[i] = 8'h80;
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    settle();
    chk_codes();
    for (int a = 0; a < 16; a++)
    begin
      lfsr = next_rand(lfsr);
      write({4'h0, a[3:0], lfsr[7:0]}, 12);
    end
    lfsr = next_rand(lfsr);
    write({lfsr[15:12], 4'hB, lfsr[7:0]}, 16);
    write(16'h035A, 12);
    dac_host_model_inst.send(16'h00FF, 8, 1'b1);
    // four bits on top of the last word give channel 5 code A6
    dac_host_model_inst.send(16'h0006, 4, 1'b0);
    settle();
    exp_q[5] = 8'hA6;
    chk_codes();
    pd_n = 1'b0;
    settle();
    chk_bit(en, 1'b0);
    pd_n = 1'b1;
    settle();
    chk_bit(en, 1'b1);
    chk_codes();
    pre_n = 1'b0;
    #1;
    foreach (exp_q[i]) exp_q[i] = 8'h80;
    chk_codes();
    settle();
    pre_n = 1'b1;
    write(16'h0B3C, 12);
    complete_run();
  end
endmodule : dac_channel_bank_test
